// ### src/boot_loader_regs.svh
`ifndef BOOT_LOADER_REGS_SVH
`define BOOT_LOADER_REGS_SVH
`define CODE_PAGE_WRITE 8'h01
`define CODE_READ 8'h02
`define CODE_WRITE_EN 8'h04
`define CODE_ERASE 8'h08
`define CODE_READ_STATUS 8'h10
`define CODE_WRITE_STATUS 8'h20
`define FLASH_READ_OPCODE 8'h03
`define HDR_BASE 24'h000000
`define HDR_BYTES 18'd6
`define SRAM_TOP_ADDR 17'h1ffff
`define SRAM_BYTES 24'h020000
`define FLASH_MAX_ADDR 24'h1fffff
`define ALIGN_4K_MASK (24'h000fff)
`define CLK_HZ 200000000
`define UART_BAUD 57600
`define UART_BIT_CYCLES (`CLK_HZ / `UART_BAUD)
`define SPI_HALF_CYCLES 4
`define SETTLE_CYCLES 18'd3
`define SY_PM 4
`define SY_SEC 3
`define SY_DBG 2
`define SY_RX 1
`define SY_MISO 0
`endif

// ### src/bl_pkg.sv
package bl_pkg;
  typedef enum logic [3:0] {
    ST_SETTLE, ST_RD_CMD, ST_RD_DATA, ST_CHECK, ST_ENCRYPT, ST_LAUNCH,
    ST_RUN, ST_HALT, ST_BR_CODE, ST_BR_LEN, ST_BR_FWD, ST_BR_RD, ST_BR_END
  } boot_state_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic sclk;
    logic mosi;
    logic [2:0] bits;
    logic [2:0] div;
    logic [7:0] sh;
  } spi_eng_t;
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    boot_state_t st;
    logic exec_mode;
    logic hdr_phase;
    logic pend;
    logic [1:0] idx;
    logic [17:0] cnt;
    logic [17:0] len;
    logic [23:0] faddr;
    logic [47:0] hdr;
    logic cs_n;
    logic spi_start;
    logic [7:0] spi_tx;
    logic sram_we;
    logic [16:0] sram_addr;
    logic [7:0] sram_wdata;
    logic [16:0] xlat;
    logic core_run;
    logic owned;
    logic enc_start;
    logic [23:0] enc_base;
    logic [23:0] enc_len;
    logic boot_error;
    logic enc_seen;
    logic rx_busy;
    logic [11:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic tx_busy;
    logic [11:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [9:0] tx_sh;
    logic [7:0] br_code;
  } loader_t;
endpackage : bl_pkg

// ### src/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
  logic start;
  logic [7:0] tx;
  logic busy;
  logic done;
  logic [7:0] rx;
  modport master (output start, output tx, input busy, input done,
                  input rx);
  modport engine (input start, input tx, output busy, output done,
                  output rx);
endinterface : spi_link_if

// ### src/spi_byte_engine.sv
`timescale 1ns/1ps
`include "boot_loader_regs.svh"
module spi_byte_engine (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  spi_link_if.engine link,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out
);
  bl_pkg::spi_eng_t q;
  bl_pkg::spi_eng_t d;

  // Mode 0: data set while clock low, sampled on rising edge
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (link.start) begin
        d.busy = 1'b1;
        d.sh = link.tx;
        d.mosi = link.tx[7];
        d.bits = 3'd0;
        d.div = 3'd0;
      end
    end else if (q.div != 3'(`SPI_HALF_CYCLES - 1)) begin
      d.div = q.div + 3'd1;
    end else begin
      d.div = 3'd0;
      if (!q.sclk) begin
        d.sclk = 1'b1;
        d.sh = {q.sh[6:0], miso_in};
      end else begin
        d.sclk = 1'b0;
        if (q.bits == 3'd7) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end else begin
          d.bits = q.bits + 3'd1;
          d.mosi = q.sh[7];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.busy = q.busy;
  assign link.done = q.done;
  assign link.rx = q.sh;
  assign sclk_out = q.sclk;
  assign mosi_out = q.mosi;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_sclk_idle_low;
    !q.busy |-> !q.sclk;
  endproperty
  a_sclk_idle_low: assert property (p_sclk_idle_low)
    else $error("SPI clock high while idle");

  property p_byte_time;
    $rose(q.busy) |-> ##64 q.done;
  endproperty
  a_byte_time: assert property (p_byte_time)
    else $error("SPI byte did not end after 16 half periods");
endmodule : spi_byte_engine

// ### src/boot_loader_flash_copy.sv
`timescale 1ns/1ps
`include "boot_loader_regs.svh"
module boot_loader_flash_copy (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic program_mode_n_in,
  input wire logic secure_boot_select_in,
  input wire logic debug_mode_in,
  input wire logic flash_sn_valid_in,
  input wire logic serial_number_input_ok_in,
  input wire logic reload_req_in,
  input wire logic wdt_timeout_in,
  input wire logic wdt_reload_en_in,
  input wire logic encrypt_done_in,
  input wire logic [16:0] cpu_data_addr_in,
  input wire logic uart_rx_in,
  input wire logic spi_miso_in,
  output logic uart_tx_out,
  output logic spi_cs_n_out,
  output logic spi_sclk_out,
  output logic spi_mosi_out,
  output logic [16:0] sram_addr_out,
  output logic [7:0] sram_wdata_out,
  output logic sram_we_out,
  output logic [16:0] cpu_data_xlat_out,
  output logic core_run_out,
  output logic pins_owned_out,
  output logic encrypt_start_out,
  output logic [23:0] encrypt_base_out,
  output logic [23:0] encrypt_len_out,
  output logic boot_error_out,
  output logic encrypted_seen_out
);
  bl_pkg::loader_t q;
  bl_pkg::loader_t d;
  spi_link_if link();

  spi_byte_engine u_spi (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .link(link.engine),
    .miso_in(q.s2[`SY_MISO]),
    .sclk_out(spi_sclk_out),
    .mosi_out(spi_mosi_out)
  );

  assign link.start = q.spi_start;
  assign link.tx = q.spi_tx;

  function automatic logic [7:0] addr_byte(input logic [23:0] a,
                                           input logic [1:0] i);
    unique case (i)
      2'd0: addr_byte = `FLASH_READ_OPCODE;
      2'd1: addr_byte = a[23:16];
      2'd2: addr_byte = a[15:8];
      2'd3: addr_byte = a[7:0];
    endcase
  endfunction : addr_byte

  always_comb begin
    logic [23:0] img_start;
    logic [23:0] img_end;
    logic [23:0] img_span;
    logic [23:0] img_round;
    logic [17:0] img_size;
    logic [8:0] n;
    logic img_ok;
    logic sn_ok;
    logic start_boot;
    d = q;
    img_start = q.hdr[47:24];
    img_end = q.hdr[23:0];
    img_span = img_end - img_start;
    img_size = img_span[17:0] + 18'd1;
    img_round = ({6'h00, img_size} + `ALIGN_4K_MASK) & ~`ALIGN_4K_MASK;
    img_ok = (img_start <= img_end) && (img_end <= `FLASH_MAX_ADDR) &&
             (img_span < `SRAM_BYTES);
    sn_ok = flash_sn_valid_in | serial_number_input_ok_in;
    n = {1'b0, q.rx_sh} + 9'd1;
    start_boot = 1'b0;
    d.s1 = {program_mode_n_in, secure_boot_select_in, debug_mode_in,
            uart_rx_in, spi_miso_in};
    d.s2 = q.s1;
    d.spi_start = 1'b0;
    d.sram_we = 1'b0;
    d.enc_start = 1'b0;
    d.rx_valid = 1'b0;
    d.xlat = `SRAM_TOP_ADDR - cpu_data_addr_in;

    // Serial receiver, 8N1, sampled mid bit
    if (!q.rx_busy) begin
      if (!q.s2[`SY_RX]) begin
        d.rx_busy = 1'b1;
        d.rx_cnt = 12'(`UART_BIT_CYCLES / 2);
        d.rx_bits = 4'd0;
      end
    end else if (q.rx_cnt != 12'd0) begin
      d.rx_cnt = q.rx_cnt - 12'd1;
    end else begin
      d.rx_cnt = 12'(`UART_BIT_CYCLES - 1);
      d.rx_bits = q.rx_bits + 4'd1;
      if (q.rx_bits == 4'd0) begin
        d.rx_busy = !q.s2[`SY_RX];
      end else if (q.rx_bits == 4'd9) begin
        d.rx_busy = 1'b0;
        d.rx_valid = q.s2[`SY_RX];
      end else begin
        d.rx_sh = {q.s2[`SY_RX], q.rx_sh[7:1]};
      end
    end

    // Serial transmitter, shifts in idle ones behind the frame
    if (q.tx_busy) begin
      if (q.tx_cnt != 12'd0) begin
        d.tx_cnt = q.tx_cnt - 12'd1;
      end else begin
        d.tx_cnt = 12'(`UART_BIT_CYCLES - 1);
        d.tx_sh = {1'b1, q.tx_sh[9:1]};
        d.tx_bits = q.tx_bits + 4'd1;
        if (q.tx_bits == 4'd9) begin
          d.tx_busy = 1'b0;
        end
      end
    end

    unique case (q.st)
      bl_pkg::ST_SETTLE: begin
        if (q.cnt == `SETTLE_CYCLES) begin
          d.exec_mode = q.s2[`SY_PM];
          if (!q.s2[`SY_PM]) begin
            d.st = bl_pkg::ST_BR_CODE;
          end else begin
            start_boot = 1'b1;
          end
        end else begin
          d.cnt = q.cnt + 18'd1;
        end
      end
      bl_pkg::ST_RD_CMD: begin
        d.cs_n = 1'b0;
        if (!q.pend) begin
          d.spi_start = 1'b1;
          d.spi_tx = addr_byte(q.faddr, q.idx);
          d.pend = 1'b1;
        end else if (link.done) begin
          d.pend = 1'b0;
          if (q.idx == 2'd3) begin
            d.st = bl_pkg::ST_RD_DATA;
            d.cnt = 18'd0;
          end else begin
            d.idx = q.idx + 2'd1;
          end
        end
      end
      bl_pkg::ST_RD_DATA: begin
        if (!q.pend) begin
          d.spi_start = 1'b1;
          d.spi_tx = 8'h00;
          d.pend = 1'b1;
        end else if (link.done) begin
          d.pend = 1'b0;
          d.cnt = q.cnt + 18'd1;
          if (q.hdr_phase) begin
            d.hdr = {q.hdr[39:0], link.rx};
          end else begin
            d.sram_we = 1'b1;
            d.sram_addr = q.cnt[16:0];
            d.sram_wdata = link.rx;
          end
          if (q.cnt == q.len - 18'd1) begin
            d.cs_n = 1'b1;
            d.st = q.hdr_phase ? bl_pkg::ST_CHECK : bl_pkg::ST_LAUNCH;
          end
        end
      end
      bl_pkg::ST_CHECK: begin
        d.idx = 2'd0;
        d.hdr_phase = 1'b0;
        d.faddr = img_start;
        if (!img_ok) begin
          // Garbled header means encrypted code only when secure
          d.enc_seen = q.s2[`SY_SEC];
          d.boot_error = 1'b1;
          d.st = bl_pkg::ST_HALT;
        end else if (q.s2[`SY_SEC] && !q.s2[`SY_DBG] && q.exec_mode &&
                     sn_ok && (img_start[11:0] == 12'h000)) begin
          d.enc_start = 1'b1;
          d.enc_base = img_start;
          d.enc_len = img_round;
          d.len = img_round[17:0];
          d.st = bl_pkg::ST_ENCRYPT;
        end else begin
          d.len = img_size;
          d.st = bl_pkg::ST_RD_CMD;
        end
      end
      bl_pkg::ST_ENCRYPT: begin
        if (encrypt_done_in) begin
          d.st = bl_pkg::ST_RD_CMD;
        end
      end
      bl_pkg::ST_LAUNCH: begin
        d.core_run = 1'b1;
        d.owned = 1'b0;
        d.st = bl_pkg::ST_RUN;
      end
      bl_pkg::ST_RUN, bl_pkg::ST_HALT: begin
        if (reload_req_in || (wdt_timeout_in && wdt_reload_en_in)) begin
          start_boot = 1'b1;
        end
      end
      bl_pkg::ST_BR_CODE: begin
        d.cs_n = 1'b1;
        if (q.rx_valid) begin
          d.br_code = q.rx_sh;
          d.st = bl_pkg::ST_BR_LEN;
        end
      end
      bl_pkg::ST_BR_LEN: begin
        if (q.rx_valid) begin
          d.st = bl_pkg::ST_BR_FWD;
          d.len = 18'd0;
          // Forward count covers opcode, address and host data
          unique case (q.br_code)
            `CODE_PAGE_WRITE: d.cnt = 18'd4 + {9'd0, n};
            `CODE_READ: begin
              d.cnt = 18'd4;
              d.len = {9'd0, n};
            end
            `CODE_WRITE_EN: d.cnt = 18'd1;
            `CODE_ERASE: d.cnt = 18'd4;
            `CODE_READ_STATUS: begin
              d.cnt = 18'd1;
              d.len = 18'd1;
            end
            `CODE_WRITE_STATUS: d.cnt = 18'd2;
            default: begin
              d.cnt = 18'd0;
              d.st = bl_pkg::ST_BR_CODE;
            end
          endcase
        end
      end
      bl_pkg::ST_BR_FWD: begin
        if (q.cnt == 18'd0) begin
          d.st = (q.len != 18'd0) ? bl_pkg::ST_BR_RD : bl_pkg::ST_BR_END;
        end else if (!q.pend) begin
          if (q.rx_valid) begin
            d.cs_n = 1'b0;
            d.spi_start = 1'b1;
            d.spi_tx = q.rx_sh;
            d.pend = 1'b1;
          end
        end else if (link.done) begin
          d.pend = 1'b0;
          d.cnt = q.cnt - 18'd1;
        end
      end
      bl_pkg::ST_BR_RD: begin
        if (q.len == 18'd0) begin
          d.st = bl_pkg::ST_BR_END;
        end else if (!q.pend) begin
          if (!q.tx_busy) begin
            d.spi_start = 1'b1;
            d.spi_tx = 8'h00;
            d.pend = 1'b1;
          end
        end else if (link.done) begin
          d.pend = 1'b0;
          d.len = q.len - 18'd1;
          d.tx_sh = {1'b1, link.rx, 1'b0};
          d.tx_busy = 1'b1;
          d.tx_cnt = 12'(`UART_BIT_CYCLES - 1);
          d.tx_bits = 4'd0;
        end
      end
      bl_pkg::ST_BR_END: begin
        d.cs_n = 1'b1;
        d.st = bl_pkg::ST_BR_CODE;
      end
    endcase

    if (start_boot) begin
      d.st = bl_pkg::ST_RD_CMD;
      d.hdr_phase = 1'b1;
      d.faddr = `HDR_BASE;
      d.len = `HDR_BYTES;
      d.idx = 2'd0;
      d.pend = 1'b0;
      d.core_run = 1'b0;
      d.owned = 1'b1;
      d.boot_error = 1'b0;
      d.enc_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.tx_sh <= '1;
      q.owned <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign uart_tx_out = q.tx_sh[0];
  assign spi_cs_n_out = q.cs_n;
  assign sram_addr_out = q.sram_addr;
  assign sram_wdata_out = q.sram_wdata;
  assign sram_we_out = q.sram_we;
  assign cpu_data_xlat_out = q.xlat;
  assign core_run_out = q.core_run;
  assign pins_owned_out = q.owned;
  assign encrypt_start_out = q.enc_start;
  assign encrypt_base_out = q.enc_base;
  assign encrypt_len_out = q.enc_len;
  assign boot_error_out = q.boot_error;
  assign encrypted_seen_out = q.enc_seen;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_copy_begin;
    q.st == bl_pkg::ST_RD_CMD && !q.hdr_phase && q.idx == 2'd3 &&
    q.pend && link.done;
  endsequence
  sequence s_reload;
    q.st == bl_pkg::ST_RUN && (reload_req_in ||
    (wdt_timeout_in && wdt_reload_en_in));
  endsequence

  property p_copy_from_zero;
    s_copy_begin |-> ##[60:72] (q.sram_we && q.sram_addr == 17'h00000);
  endproperty
  a_copy_from_zero: assert property (p_copy_from_zero)
    else $error("First SRAM write not at address zero");

  property p_xlat;
    1'b1 |=> 17'(q.xlat + $past(cpu_data_addr_in)) == `SRAM_TOP_ADDR;
  endproperty
  a_xlat: assert property (p_xlat)
    else $error("Volatile address not mirrored from SRAM top");

  property p_run_after_copy;
    $rose(q.core_run) |-> $past(q.st) == bl_pkg::ST_LAUNCH && q.cs_n;
  endproperty
  a_run_after_copy: assert property (p_run_after_copy)
    else $error("Core started before copy finished");

  property p_copy_len;
    $rose(q.core_run) |-> q.sram_addr == 17'(q.len - 18'd1);
  endproperty
  a_copy_len: assert property (p_copy_len)
    else $error("Copied byte count differs from image size");

  property p_reload;
    s_reload |=> !q.core_run && q.owned && q.hdr_phase &&
                 q.st == bl_pkg::ST_RD_CMD;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Reload request did not restart the copy");

  property p_enc_gate;
    q.enc_start |-> q.s2[`SY_SEC] && !q.s2[`SY_DBG] && q.exec_mode &&
                    q.enc_base[11:0] == 12'h000;
  endproperty
  a_enc_gate: assert property (p_enc_gate)
    else $error("Encryption started without its preconditions");

  property p_enc_round;
    q.enc_start |-> q.enc_len[11:0] == 12'h000 &&
                    q.len == q.enc_len[17:0];
  endproperty
  a_enc_round: assert property (p_enc_round)
    else $error("Encrypted length not rounded to 4 KB");

  property p_quiet_encrypt;
    q.st == bl_pkg::ST_ENCRYPT |-> q.cs_n && !q.core_run && q.owned;
  endproperty
  a_quiet_encrypt: assert property (p_quiet_encrypt)
    else $error("Activity seen during encryption");

  property p_read_opcode;
    q.spi_start && q.st == bl_pkg::ST_RD_CMD && q.idx == 2'd0 |->
      q.spi_tx == `FLASH_READ_OPCODE;
  endproperty
  a_read_opcode: assert property (p_read_opcode)
    else $error("Copy read does not use opcode 03");

  property p_bridge_mode;
    q.st == bl_pkg::ST_SETTLE && q.cnt == `SETTLE_CYCLES &&
      !q.s2[`SY_PM] |=> q.st == bl_pkg::ST_BR_CODE && !q.core_run;
  endproperty
  a_bridge_mode: assert property (p_bridge_mode)
    else $error("Program mode low did not enter the bridge");

  property p_release;
    q.core_run |-> !q.owned;
  endproperty
  a_release: assert property (p_release)
    else $error("Pins still owned while core runs");
endmodule : boot_loader_flash_copy

// ### dv/spi_flash_model.sv
`timescale 1ns/1ps
module spi_flash_model (
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out
);
  logic [7:0] mem [int];
  logic [31:0] frame_q [$];
  logic [31:0] hdr = 32'h00000000;
  logic [7:0] sh = 8'h00;
  logic [7:0] out_q = 8'h00;
  logic [23:0] addr = 24'h000000;
  int bitn = 0;
  int bytn = 0;
  function automatic logic [7:0] rd(input logic [23:0] a);
    rd = mem.exists(int'(a)) ? mem[int'(a)] : (a[7:0] ^ 8'ha5);
  endfunction : rd
  initial miso_out = 1'b0;
  always @(negedge cs_n_in) begin
    bitn = 0;
    bytn = 0;
  end
  // Released line inverts its last driven value on deselect
  always @(posedge cs_n_in) begin
    miso_out = ~miso_out;
  end
  // Mode 0 sampling; opcode then address MSB first, then streamed data
  always @(posedge sclk_in) begin
    if (!cs_n_in) begin
      sh = {sh[6:0], mosi_in};
      bitn++;
      if (bitn == 8) begin
        bitn = 0;
        bytn++;
        if (bytn <= 4) hdr = {hdr[23:0], sh};
        if (bytn == 4) begin
          frame_q.push_back(hdr);
          addr = hdr[23:0];
        end
        if (bytn >= 4 && hdr[31:24] == 8'h03) begin
          out_q = rd(addr);
          addr++;
        end
      end
    end
  end
  always @(negedge sclk_in) begin
    if (!cs_n_in && bytn >= 4) begin
      miso_out = out_q[7];
      out_q = {out_q[6:0], 1'b0};
    end
  end
endmodule : spi_flash_model

// ### dv/boot_loader_flash_copy_tb.sv
`timescale 1ns/1ps
module boot_loader_flash_copy_tb;
  logic sys_clk_in = 1'b0, resetn_in = 1'b0, program_mode_n_in = 1'b1;
  logic secure_boot_select_in = 1'b0, debug_mode_in = 1'b0;
  logic flash_sn_valid_in = 1'b0, serial_number_input_ok_in = 1'b0;
  logic reload_req_in = 1'b0, wdt_timeout_in = 1'b0;
  logic wdt_reload_en_in = 1'b0, encrypt_done_in = 1'b0;
  logic uart_rx_in = 1'b1;
  logic [16:0] cpu_data_addr_in = 17'h00000;
  logic spi_miso_in, uart_tx_out, spi_cs_n_out, spi_sclk_out, spi_mosi_out;
  logic sram_we_out, core_run_out, pins_owned_out, encrypt_start_out;
  logic boot_error_out, encrypted_seen_out;
  logic [16:0] sram_addr_out, cpu_data_xlat_out;
  logic [7:0] sram_wdata_out;
  logic [23:0] encrypt_base_out, encrypt_len_out, enc_base, enc_len;
  logic [7:0] sram [int];
  int wr_cnt = 0, enc_cnt = 0, fails = 0, comparisons = 0;

  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  boot_loader_flash_copy u_boot_loader_flash_copy (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .program_mode_n_in(program_mode_n_in),
    .secure_boot_select_in(secure_boot_select_in),
    .debug_mode_in(debug_mode_in), .flash_sn_valid_in(flash_sn_valid_in),
    .serial_number_input_ok_in(serial_number_input_ok_in),
    .reload_req_in(reload_req_in), .wdt_timeout_in(wdt_timeout_in),
    .wdt_reload_en_in(wdt_reload_en_in),
    .encrypt_done_in(encrypt_done_in), .cpu_data_addr_in(cpu_data_addr_in),
    .uart_rx_in(uart_rx_in), .spi_miso_in(spi_miso_in),
    .uart_tx_out(uart_tx_out), .spi_cs_n_out(spi_cs_n_out),
    .spi_sclk_out(spi_sclk_out), .spi_mosi_out(spi_mosi_out),
    .sram_addr_out(sram_addr_out), .sram_wdata_out(sram_wdata_out),
    .sram_we_out(sram_we_out), .cpu_data_xlat_out(cpu_data_xlat_out),
    .core_run_out(core_run_out), .pins_owned_out(pins_owned_out),
    .encrypt_start_out(encrypt_start_out),
    .encrypt_base_out(encrypt_base_out), .encrypt_len_out(encrypt_len_out),
    .boot_error_out(boot_error_out), .encrypted_seen_out(encrypted_seen_out)
  );

  spi_flash_model u_spi_flash_model (
    .cs_n_in(spi_cs_n_out), .sclk_in(spi_sclk_out),
    .mosi_in(spi_mosi_out), .miso_out(spi_miso_in)
  );

  always @(posedge sys_clk_in) begin
    if (sram_we_out === 1'b1) begin
      sram[int'(sram_addr_out)] = sram_wdata_out;
      wr_cnt++;
    end
    if (encrypt_start_out === 1'b1) begin
      enc_cnt++;
      enc_base = encrypt_base_out;
      enc_len = encrypt_len_out;
    end
  end

  task automatic close_out;
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc

  // Bounded wait for release, error hold or encryption request
  task automatic wait_boot;
    int i;
    for (i = 0; i < 4000; i++) begin
      if (core_run_out === 1'b1 || boot_error_out === 1'b1 || enc_cnt > 0)
        break;
      cyc(1);
    end
    if (i == 4000) begin
      fails++;
      close_out();
    end
  endtask : wait_boot

  task automatic do_boot(input logic [23:0] s, input logic [23:0] e);
    logic [47:0] h;
    int i;
    h = {s, e};
    u_spi_flash_model.mem.delete();
    u_spi_flash_model.frame_q.delete();
    for (i = 0; i < 6; i++) u_spi_flash_model.mem[i] = h[47-8*i -: 8];
    for (i = 0; i < 8; i++) u_spi_flash_model.mem[int'(s) + i] = 8'h30 + 8'(i);
    sram.delete();
    wr_cnt = 0;
    enc_cnt = 0;
    resetn_in = 1'b0;
    cyc(5);
    resetn_in = 1'b1;
    wait_boot();
  endtask : do_boot

  task automatic t_boot_copy;
    int i;
    do_boot(24'h000010, 24'h000017);
    check(32'(core_run_out), 32'h1);
    check(32'(pins_owned_out), 32'h0);
    check(32'(wr_cnt), 32'h8);
    check(u_spi_flash_model.frame_q[0], 32'h03000000);
    check(u_spi_flash_model.frame_q[1], 32'h03000010);
    for (i = 0; i < 8; i++) check(32'(sram[i]), 32'h30 + i);
    check(32'({spi_cs_n_out, spi_sclk_out}), 32'h2);
    check(32'(enc_cnt), 32'h0);
  endtask : t_boot_copy

  task automatic t_xlat;
    cpu_data_addr_in = 17'h00005;
    cyc(2);
    check(32'(cpu_data_xlat_out), 32'h1fffa);
    cpu_data_addr_in = 17'h1ffff;
    cyc(2);
    check(32'(cpu_data_xlat_out), 32'h0);
  endtask : t_xlat

  // Software reload, watchdog without and with permission
  task automatic t_reload;
    int k;
    int i;
    for (k = 0; k < 3; k++) begin
      wr_cnt = 0;
      reload_req_in = (k == 0);
      wdt_timeout_in = (k > 0);
      wdt_reload_en_in = (k == 2);
      cyc(1);
      reload_req_in = 1'b0;
      wdt_timeout_in = 1'b0;
      for (i = 0; i < 20; i++) begin
        if (core_run_out === 1'b0) break;
        cyc(1);
      end
      check(32'(i < 20), 32'(k != 1));
      wait_boot();
      check(32'(wr_cnt), (k == 1) ? 32'h0 : 32'h8);
    end
  endtask : t_reload

  task automatic t_bad_header;
    int k;
    for (k = 0; k < 2; k++) begin
      secure_boot_select_in = k[0];
      do_boot(24'h000020, 24'h000010);
      check(32'(boot_error_out), 32'h1);
      check(32'(encrypted_seen_out), 32'(k));
      check(32'({core_run_out, 8'(enc_cnt)}), 32'h0);
    end
  endtask : t_bad_header

  // Both serial sources, then debug high, then unaligned start
  task automatic t_encrypt;
    int k;
    logic [23:0] s;
    for (k = 0; k < 4; k++) begin
      secure_boot_select_in = 1'b1;
      flash_sn_valid_in = (k != 1);
      serial_number_input_ok_in = (k == 1);
      debug_mode_in = (k == 2);
      s = (k == 3) ? 24'h001010 : 24'h001000;
      do_boot(s, s + 24'h000004);
      check(32'(enc_cnt), 32'(k < 2));
      if (k < 2) begin
        check(32'(enc_base), 32'h1000);
        check(32'(enc_len), 32'h1000);
        // Let encryption finish before any reset
        encrypt_done_in = 1'b1;
        cyc(1);
        encrypt_done_in = 1'b0;
        cyc(3);
        check(32'(spi_cs_n_out), 32'h0);
        check(32'(core_run_out), 32'h0);
      end else begin
        check(32'(core_run_out), 32'h1);
        check(32'(wr_cnt), 32'h5);
      end
    end
  endtask : t_encrypt

  // Program mode low at reset: bridge idle, core held, pins kept
  task automatic t_bridge;
    program_mode_n_in = 1'b0;
    resetn_in = 1'b0;
    cyc(5);
    resetn_in = 1'b1;
    cyc(20);
    check(32'({core_run_out, pins_owned_out}), 32'h1);
    check(32'({spi_cs_n_out, uart_tx_out}), 32'h3);
    program_mode_n_in = 1'b1;
  endtask : t_bridge

  initial begin
    t_boot_copy();
    t_xlat();
    t_reload();
    t_bad_header();
    t_encrypt();
    t_bridge();
    close_out();
  end
endmodule : boot_loader_flash_copy_tb
